// file: design/fir_pkg.sv
/*
 * constants and types shared by the streaming fir filter, its converter model and its bench.
 * assumes a single clock domain and a synchronous, active-high reset.
 */
package fir_pkg;

   // -----------------------------------------------------------------
   // widths and counts
   // -----------------------------------------------------------------
   localparam int unsigned TAPS       = 24;
   localparam int unsigned HALF_TAPS  = 12;
   localparam int unsigned TAP_W      = 5;
   localparam int unsigned SAMPLE_W   = 12;
   localparam int unsigned COEF_W     = 16;
   localparam int unsigned FRAC_BITS  = 16;
   localparam int unsigned PROD_W     = 29;
   localparam int unsigned ACC_W      = 64;
   localparam int unsigned WORD_W     = 32;
   localparam int unsigned OUT_W      = 12;
   localparam int unsigned CYC_PER_TAP = 3;

   // -----------------------------------------------------------------
   // reset values
   // -----------------------------------------------------------------
   localparam logic [TAP_W-1:0]    TAP_RST = 5'h00;
   localparam logic [ACC_W-1:0]    ACC_RST = 64'h0000_0000_0000_0000;
   localparam logic [SAMPLE_W-1:0] SMP_RST = 12'h000;
   localparam logic [WORD_W-1:0]   WRD_RST = 32'h0000_0000;

   // -----------------------------------------------------------------
   // sequencer states
   // -----------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE        = 3'b000,
      ST_LOAD_COEF   = 3'b001,
      ST_LOAD_SAMPLE = 3'b010,
      ST_WAIT        = 3'b011,
      ST_DELIVER     = 3'b100
   } fir_state_t;

   // -----------------------------------------------------------------
   // tap weights, q16; second half mirrors the first
   // -----------------------------------------------------------------
   function automatic logic signed [COEF_W-1:0] tap_weights(input logic [TAP_W-1:0] idx);
      logic [TAP_W-1:0] h;
      h = (idx < TAP_W'(HALF_TAPS)) ? idx : TAP_W'(TAPS - 1) - idx;
      case (h)
         5'h00:   tap_weights = -16'sd62;
         5'h01:   tap_weights = -16'sd153;
         5'h02:   tap_weights = -16'sd56;
         5'h03:   tap_weights = 16'sd434;
         5'h04:   tap_weights = 16'sd969;
         5'h05:   tap_weights = 16'sd571;
         5'h06:   tap_weights = -16'sd1291;
         5'h07:   tap_weights = -16'sd3237;
         5'h08:   tap_weights = -16'sd2173;
         5'h09:   tap_weights = 16'sd3989;
         5'h0A:   tap_weights = 16'sd13381;
         default: tap_weights = 16'sd20518;
      endcase
   endfunction : tap_weights

endpackage : fir_pkg

// file: design/fir_skid.sv
/*
 * two-entry buffer between the filter and the output converter.
 * assumes the consumer may hold ready low for any time; no word is lost.
 */
module fir_skid #(
   parameter int unsigned W = 12
) (
   // clock and reset
   input  wire logic         clk_i,
   input  wire logic         srst_i,
   // filling side
   input  wire logic         in_valid_i,
   input  wire logic [W-1:0] in_data_i,
   output logic              in_ready_o,
   // draining side
   output logic              out_valid_o,
   output logic [W-1:0]      out_data_o,
   input  wire logic         out_ready_i
);

   logic         tail_v;
   logic [W-1:0] tail_d;
   wire          push = in_valid_i & in_ready_o;
   wire          move = ~out_valid_o | out_ready_i;

   // full when the second entry is occupied; stalls the filter
   assign in_ready_o = ~tail_v;

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         out_valid_o <= 1'b0;
         out_data_o  <= '0;
         tail_v      <= 1'b0;
         tail_d      <= '0;
      end else begin
         if (move) begin
            out_valid_o <= tail_v | push;
            out_data_o  <= tail_v ? tail_d : in_data_i;
            tail_v      <= 1'b0;
         end else if (push) begin
            tail_v <= 1'b1;
            tail_d <= in_data_i;
         end
      end
   end

endmodule : fir_skid

// file: design/fir_filter.sv
/*
 * 24-tap streaming fir filter with a sequential multiply-accumulate engine.
 * assumes sample_ready_event_i is a one-cycle pulse with sample_i valid in
 * the same cycle, and that the output converter takes words by valid/ready.
 */
module fir_filter (
   // clock and reset
   input  wire logic                          clk_i,
   input  wire logic                          srst_i,
   // sample source
   input  wire logic                          sample_ready_event_i,
   input  wire logic [fir_pkg::SAMPLE_W-1:0]  sample_i,
   // output converter
   output logic                               out_valid_o,
   output logic [fir_pkg::OUT_W-1:0]          out_data_o,
   input  wire logic                          out_ready_i,
   // status
   output logic                               done_o,
   output logic                               busy_o,
   output logic                               overrun_o,
   output logic [fir_pkg::WORD_W-1:0]         result_high_word_o
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   fir_pkg::fir_state_t                        state;
   fir_pkg::fir_state_t                        next_state;
   logic                                       pending;
   logic [fir_pkg::SAMPLE_W-1:0]               held_sample;
   logic [fir_pkg::SAMPLE_W-1:0]               sample_history [0:fir_pkg::TAPS-1];
   logic [fir_pkg::TAP_W-1:0]                  tap;
   logic signed [fir_pkg::COEF_W-1:0]          coef_op;
   logic signed [fir_pkg::PROD_W-1:0]          product;
   logic signed [fir_pkg::ACC_W-1:0]           acc;
   logic                                       buf_ready;

   // ----------------------------------------------------------------
   // decoding
   // ----------------------------------------------------------------
   wire start     = (state == fir_pkg::ST_IDLE) & pending;
   wire last_tap  = (tap == fir_pkg::TAP_W'(fir_pkg::TAPS - 1));
   wire deliver   = (state == fir_pkg::ST_DELIVER) & buf_ready;
   wire signed [fir_pkg::ACC_W-1:0]  acc_q16 = acc >>> fir_pkg::FRAC_BITS;
   wire [fir_pkg::WORD_W-1:0]        result_low_word  = acc_q16[fir_pkg::WORD_W-1:0];
   wire [fir_pkg::WORD_W-1:0]        result_high_word = acc_q16[fir_pkg::ACC_W-1:fir_pkg::WORD_W];
   // only the low word is used; values must fit, no saturation is applied
   wire [fir_pkg::OUT_W-1:0]         result_out = result_low_word[fir_pkg::OUT_W-1:0];
   wire signed [fir_pkg::SAMPLE_W:0] sample_op = {1'b0, sample_history[tap]};
   wire signed [fir_pkg::PROD_W-1:0] mul_res = fir_pkg::PROD_W'(sample_op * coef_op);
   wire signed [fir_pkg::ACC_W-1:0]  prod_ext = fir_pkg::ACC_W'(product);

   // ----------------------------------------------------------------
   // sequencer
   // ----------------------------------------------------------------
   always_comb begin
      next_state = state;
      case (state)
         fir_pkg::ST_IDLE:        if (pending) next_state = fir_pkg::ST_LOAD_COEF;
         fir_pkg::ST_LOAD_COEF:   next_state = fir_pkg::ST_LOAD_SAMPLE;
         fir_pkg::ST_LOAD_SAMPLE: next_state = fir_pkg::ST_WAIT;
         fir_pkg::ST_WAIT:        next_state = last_tap ? fir_pkg::ST_DELIVER : fir_pkg::ST_LOAD_COEF;
         fir_pkg::ST_DELIVER:     if (buf_ready) next_state = fir_pkg::ST_IDLE;
         default:                 next_state = fir_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         state <= fir_pkg::ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // ----------------------------------------------------------------
   // sample capture; an event during a run waits, a newer one overwrites
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         pending     <= 1'b0;
         held_sample <= fir_pkg::SMP_RST;
         overrun_o   <= 1'b0;
      end else begin
         pending   <= sample_ready_event_i | (pending & ~start);
         overrun_o <= sample_ready_event_i & pending & ~start;
         if (sample_ready_event_i) begin
            held_sample <= sample_i;
         end
      end
   end

   // ----------------------------------------------------------------
   // history shift line
   // ----------------------------------------------------------------
   // head and body split at elaboration, so no entry ever names index -1
   generate
      for (genvar i = 0; i < fir_pkg::TAPS; i++) begin : g_hist
         if (i == 0) begin : g_head
            always_ff @(posedge clk_i) begin
               if (srst_i) begin
                  sample_history[i] <= fir_pkg::SMP_RST;
               end else if (start) begin
                  sample_history[i] <= held_sample;
               end
            end
         end else begin : g_body
            always_ff @(posedge clk_i) begin
               if (srst_i) begin
                  sample_history[i] <= fir_pkg::SMP_RST;
               end else if (start) begin
                  sample_history[i] <= sample_history[i-1];
               end
            end
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // multiply-accumulate engine
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         tap     <= fir_pkg::TAP_RST;
         coef_op <= '0;
         product <= '0;
         acc     <= fir_pkg::ACC_RST;
      end else begin
         if (start) begin
            tap <= fir_pkg::TAP_RST;
         end else if (state == fir_pkg::ST_WAIT && !last_tap) begin
            tap <= tap + 5'h01;
         end
         if (state == fir_pkg::ST_LOAD_COEF) begin
            coef_op <= fir_pkg::tap_weights(tap);
         end
         if (state == fir_pkg::ST_LOAD_SAMPLE) begin
            product <= mul_res;
         end
         if (deliver) begin
            acc <= fir_pkg::ACC_RST;
         end else if (state == fir_pkg::ST_WAIT) begin
            acc <= acc + prod_ext;
         end
      end
   end

   // ----------------------------------------------------------------
   // status outputs
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         done_o             <= 1'b0;
         busy_o             <= 1'b0;
         result_high_word_o <= fir_pkg::WRD_RST;
      end else begin
         done_o <= deliver;
         busy_o <= (next_state != fir_pkg::ST_IDLE);
         if (deliver) begin
            result_high_word_o <= result_high_word;
         end
      end
   end

   // ----------------------------------------------------------------
   // output buffer; full buffer holds the sequencer in deliver
   // ----------------------------------------------------------------
   fir_skid #(
      .W (fir_pkg::OUT_W)
   ) u_skid (
      .clk_i       (clk_i),
      .srst_i      (srst_i),
      .in_valid_i  (state == fir_pkg::ST_DELIVER),
      .in_data_i   (result_out),
      .in_ready_o  (buf_ready),
      .out_valid_o (out_valid_o),
      .out_data_o  (out_data_o),
      .out_ready_i (out_ready_i)
   );

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   sequence s_tap;
      state == fir_pkg::ST_LOAD_COEF ##1 state == fir_pkg::ST_LOAD_SAMPLE ##1 state == fir_pkg::ST_WAIT;
   endsequence

   property p_start;
      @(posedge clk_i) disable iff (srst_i)
      (state == fir_pkg::ST_IDLE && !pending) |=> state == fir_pkg::ST_IDLE;
   endproperty
   a_start: assert property (p_start) else $error("sequencer left idle without a sample");

   property p_shift;
      @(posedge clk_i) disable iff (srst_i)
      start |=> (sample_history[0] == $past(held_sample))
                && (sample_history[fir_pkg::TAPS-1] == $past(sample_history[fir_pkg::TAPS-2]));
   endproperty
   a_shift: assert property (p_shift) else $error("history did not shift by one");

   property p_tap_order;
      @(posedge clk_i) disable iff (srst_i)
      (state == fir_pkg::ST_LOAD_COEF) |-> s_tap;
   endproperty
   a_tap_order: assert property (p_tap_order) else $error("tap steps out of order");

   property p_mac;
      @(posedge clk_i) disable iff (srst_i)
      (state == fir_pkg::ST_WAIT) |=> acc == $past(acc) + $past(prod_ext);
   endproperty
   a_mac: assert property (p_mac) else $error("accumulator missed a product");

   property p_run_len;
      @(posedge clk_i) disable iff (srst_i)
      start |=> ##72 state == fir_pkg::ST_DELIVER;
   endproperty
   a_run_len: assert property (p_run_len) else $error("run length is not 24 taps");

   property p_clear;
      @(posedge clk_i) disable iff (srst_i)
      done_o |-> acc == fir_pkg::ACC_RST;
   endproperty
   a_clear: assert property (p_clear) else $error("accumulator not cleared after output");

   property p_symm;
      @(posedge clk_i) disable iff (srst_i)
      (state == fir_pkg::ST_LOAD_SAMPLE) |->
         coef_op == fir_pkg::tap_weights(fir_pkg::TAP_W'(fir_pkg::TAPS - 1) - tap);
   endproperty
   a_symm: assert property (p_symm) else $error("weight table not symmetric");

   property p_done;
      @(posedge clk_i) disable iff (srst_i)
      deliver |=> done_o ##1 !done_o;
   endproperty
   a_done: assert property (p_done) else $error("completion not a single pulse");

   property p_high;
      @(posedge clk_i) disable iff (srst_i)
      deliver |=> result_high_word_o == $past(result_high_word);
   endproperty
   a_high: assert property (p_high) else $error("high word not captured");

endmodule : fir_filter

// file: tb/fir_conv_model.sv
/*
 * behavioural model of the output converter that drains the filter's buffer.
 * assumes one clock; the bench may stall it to back the filter up.
 */
module fir_conv_model (
   // clock and reset
   input  wire logic                         clk_i,
   input  wire logic                         srst_i,
   // bench control
   input  wire logic                         stall_i,
   // filter side
   input  wire logic                         out_valid_i,
   input  wire logic [fir_pkg::OUT_W-1:0]    out_data_i,
   output logic                              out_ready_o
);
   timeunit 1ns;
   timeprecision 100ps;

   // -----------------------------------------------------------------
   // acceptance
   // -----------------------------------------------------------------
   initial begin
      out_ready_o = 1'b0;
   end

   // ready moves just after the edge, never in the sampling step;
   // accepted words are judged by the bench's monitor
   always @(posedge clk_i) begin
      #1;
      out_ready_o = !stall_i && !srst_i;
   end
endmodule : fir_conv_model

// file: tb/fir_filter_bench.sv
/*
 * self-checking bench for the streaming fir filter.
 * assumes the converter model drains words; samples come from tasks here.
 */
module fir_filter_bench;
   timeunit 1ns;
   timeprecision 100ps;

   // -----------------------------------------------------------------
   // signals and bookkeeping
   // -----------------------------------------------------------------
   logic                             clk;
   logic                             srst;
   logic                             ev;
   logic                             stall;
   logic [fir_pkg::SAMPLE_W-1:0]     smp;
   logic                             out_valid;
   logic [fir_pkg::OUT_W-1:0]        out_data;
   logic                             out_ready;
   logic                             done;
   logic                             busy;
   logic                             overrun;
   logic [fir_pkg::WORD_W-1:0]       hi_word;
   int                               mismatches;
   int                               checks_done;
   int                               done_cnt;
   int                               ovr_cnt;
   logic [11:0]                      exp_q[$];
   logic [31:0]                      hi_q[$];
   logic [11:0]                      hist[24];
   localparam int signed HALFW[12] = '{-62, -153, -56, 434, 969, 571, -1291, -3237, -2173, 3989, 13381, 20518};

   fir_filter dut (.clk_i(clk), .srst_i(srst), .sample_ready_event_i(ev), .sample_i(smp),
                   .out_valid_o(out_valid), .out_data_o(out_data), .out_ready_i(out_ready),
                   .done_o(done), .busy_o(busy), .overrun_o(overrun), .result_high_word_o(hi_word));
   fir_conv_model conv (.clk_i(clk), .srst_i(srst), .stall_i(stall), .out_valid_i(out_valid),
                        .out_data_i(out_data), .out_ready_o(out_ready));

   // -----------------------------------------------------------------
   // comparison, reference model, monitor
   // -----------------------------------------------------------------
   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_word

   task automatic chk_flag(input logic got, input logic exp);
      chk_word({31'h0, got}, {31'h0, exp});
   endtask : chk_flag

   function automatic int signed wgt(input int i);
      return (i < 12) ? HALFW[i] : HALFW[23-i];
   endfunction : wgt

   // result is the q16 sum; low word gives the output, high word the status pin
   task automatic model_push(input logic [11:0] s);
      logic signed [63:0] acc;
      logic signed [63:0] res;
      for (int i = 23; i > 0; i--) hist[i] = hist[i-1];
      hist[0] = s;
      acc = 64'sh0;
      for (int i = 0; i < 24; i++) acc += 64'(wgt(i)) * $signed({52'h0, hist[i]});
      res = acc >>> 16;
      exp_q.push_back(res[11:0]);
      hi_q.push_back(res[63:32]);
   endtask : model_push

   always @(posedge clk) begin
      if (out_valid === 1'b1 && out_ready === 1'b1) begin
         if (exp_q.size() == 0) chk_flag(1'b1, 1'b0);
         else chk_word({20'h0, out_data}, {20'h0, exp_q.pop_front()});
      end
      if (done === 1'b1) begin
         done_cnt++;
         if (hi_q.size() == 0) chk_flag(1'b1, 1'b0);
         else chk_word(hi_word, hi_q.pop_front());
      end
      if (overrun === 1'b1) ovr_cnt++;
   end

   // -----------------------------------------------------------------
   // stimulus helpers
   // -----------------------------------------------------------------
   // released sample lines show the inverse, so a stale read cannot pass
   task automatic send(input logic [11:0] s);
      @(posedge clk);
      #1;
      ev  = 1'b1;
      smp = s;
      @(posedge clk);
      #1;
      ev  = 1'b0;
      smp = ~s;
   endtask : send

   task automatic wait_done(input int target);
      int n;
      n = 0;
      while (done_cnt < target && n < 600) begin
         @(posedge clk);
         n++;
      end
      #2;
      chk_flag(done_cnt >= target, 1'b1);
   endtask : wait_done

   // -----------------------------------------------------------------
   // scenarios
   // -----------------------------------------------------------------
   task automatic t_reset();
      chk_flag(out_valid, 1'b0);
      chk_flag(done, 1'b0);
      chk_flag(busy, 1'b0);
      chk_flag(overrun, 1'b0);
      chk_word(hi_word, 32'h0000_0000);
   endtask : t_reset

   // full-scale impulse timed to the cycle, then zeros walk it over all 24 weights
   task automatic t_latency_impulse();
      int n;
      int base;
      base = done_cnt;
      @(posedge clk);
      #1;
      ev  = 1'b1;
      smp = 12'hFFF;
      model_push(12'hFFF);
      n = 0;
      while (n < 120) begin
         @(posedge clk);
         #1;
         n++;
         if (n == 1) begin
            ev  = 1'b0;
            smp = 12'h000;
         end
         if (n == 2) chk_flag(busy, 1'b1);
         if (done === 1'b1) break;
      end
      chk_word(32'(n), 32'h0000_004B);
      @(posedge clk);
      #1;
      chk_flag(done, 1'b0);
      chk_flag(busy, 1'b0);
      for (int k = 1; k <= 24; k++) begin
         send(12'h000);
         model_push(12'h000);
         wait_done(base + 1 + k);
      end
   endtask : t_latency_impulse

   // a second event inside a run is held and processed next, no overrun
   task automatic t_held_pairs();
      logic [11:0] v[6];
      int          base;
      v    = '{12'h800, 12'h7FF, 12'h123, 12'hABC, 12'h001, 12'hFFE};
      base = ovr_cnt;
      for (int k = 0; k < 6; k += 2) begin
         send(v[k]);
         model_push(v[k]);
         repeat (5) @(posedge clk);
         send(v[k+1]);
         model_push(v[k+1]);
         wait_done(done_cnt + 2);
      end
      chk_word(32'(ovr_cnt - base), 32'h0000_0000);
   endtask : t_held_pairs

   task automatic t_overrun();
      int base;
      int dbase;
      base  = ovr_cnt;
      dbase = done_cnt;
      send(12'h9A5);
      model_push(12'h9A5);
      repeat (5) @(posedge clk);
      send(12'h111);
      repeat (3) @(posedge clk);
      send(12'h5C3);
      model_push(12'h5C3);
      wait_done(dbase + 2);
      repeat (80) @(posedge clk);
      chk_word(32'(done_cnt - dbase), 32'h0000_0002);
      chk_word(32'(ovr_cnt - base), 32'h0000_0001);
   endtask : t_overrun

   // converter stalls: two words buffered, third run waits, nothing lost
   task automatic t_stall();
      int          base;
      logic [11:0] head;
      base  = done_cnt;
      stall = 1'b1;
      send(12'h3E8);
      model_push(12'h3E8);
      wait_done(base + 1);
      send(12'hC00);
      model_push(12'hC00);
      wait_done(base + 2);
      send(12'h0F0);
      model_push(12'h0F0);
      repeat (150) @(posedge clk);
      #1;
      head = exp_q[0];
      chk_word({20'h0, out_data}, {20'h0, head});
      chk_word(32'(done_cnt - base), 32'h0000_0002);
      chk_flag(out_valid, 1'b1);
      chk_flag(busy, 1'b1);
      repeat (10) @(posedge clk);
      #1;
      chk_word({20'h0, out_data}, {20'h0, head});
      stall = 1'b0;
      wait_done(base + 3);
      repeat (10) @(posedge clk);
      #1;
      chk_word(32'(exp_q.size()), 32'h0000_0000);
      chk_flag(out_valid, 1'b0);
   endtask : t_stall

   // -----------------------------------------------------------------
   // run control
   // -----------------------------------------------------------------
   task automatic tally_and_finish();
      $display("checks %0d, mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : tally_and_finish

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   // about 3000 cycles are expected; this allows more than six times that
   initial begin
      #1_000_000;
      mismatches++;
      tally_and_finish();
   end

   initial begin
      mismatches  = 0;
      checks_done = 0;
      done_cnt    = 0;
      ovr_cnt     = 0;
      srst        = 1'b1;
      ev          = 1'b0;
      stall       = 1'b0;
      smp         = 12'h000;
      for (int i = 0; i < 24; i++) hist[i] = 12'h000;
      repeat (20) @(posedge clk);
      #1;
      t_reset();
      srst = 1'b0;
      t_latency_impulse();
      t_held_pairs();
      t_overrun();
      t_stall();
      tally_and_finish();
   end
endmodule : fir_filter_bench
